// ---- rtl/asl_apb_slave.sv ----
// APB slave front end with one wait state
`timescale 1ns/1ps
`default_nettype none
module asl_apb_slave (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Bank access
  asl_bank_if.slave        bus
);
  logic access;
  logic aligned;
  logic first;

  // Access phase decode
  assign access    = psel & penable;
  assign first     = access & ~pready;
  assign aligned   = (paddr[1:0] == 2'b00);
  assign bus.idx   = {2'b00, paddr[7:2]};
  assign bus.wdata = pwdata;
  // Write lands on the edge where pready is sampled high
  assign bus.wr    = access & pready & pwrite & aligned & bus.hit;

  // Ready after one wait cycle, low again after completion
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= first;
    end
  end

  // Read data and error captured in the wait cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata  <= asl_pkg::DATA_ZERO;
      pslverr <= 1'b0;
    end else if (first) begin
      prdata  <= (!pwrite && aligned && bus.hit) ? bus.rdata
                                                 : asl_pkg::DATA_ZERO;
      pslverr <= ~(aligned & bus.hit);
    end else begin
      pslverr <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/asl_bank_if.sv ----
// Register access carrier between bus slave and register bank
`timescale 1ns/1ps
`default_nettype none
interface asl_bank_if;
  logic        wr;
  logic [7:0]  idx;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        hit;

  // Bus side drives strobe, index and data
  modport slave (output wr, idx, wdata, input rdata, hit);
  // Bank side decodes and answers
  modport bank  (input wr, idx, wdata, output rdata, hit);
endinterface
`default_nettype wire

// ---- rtl/asl_pkg.sv ----
// Constants and types shared by the antenna segment level bank
package asl_pkg;

  // ----------------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SEG_N  = 8;
  localparam int unsigned CODE_W = 6;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_IDX   = 8'h24;
  localparam logic [7:0] RESULT_IDX = 8'h25;
  localparam logic [7:0] KEYED_IDX  = 8'h26;
  localparam logic [7:0] IDLE_IDX   = 8'h27;
  localparam logic [7:0] STAT_IDX   = 8'h3e;
  localparam logic [7:0] CMD_IDX    = 8'h3f;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned SRC_BIT      = 7;
  localparam int unsigned CODE_MSB     = 6;
  localparam int unsigned CODE_LSB     = 1;
  localparam int unsigned CMD_RESTORE  = 0;
  localparam int unsigned CMD_CAL      = 1;
  localparam int unsigned STAT_BUSY    = 0;
  localparam int unsigned STAT_DONE    = 1;
  localparam int unsigned STAT_FAIL    = 2;

  // ----------------------------------------------------------------------
  // Reset and special values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  MASK_RST   = 8'h00;
  localparam logic [5:0]  CODE_RST   = 6'h00;
  localparam logic [7:0]  MASK_ALL   = 8'hff;
  localparam logic [31:0] DATA_ZERO  = 32'h0000_0000;

  // Calibration sequencer states
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN  = 2'b10
  } asl_cal_state_type;

  // Widen an eight bit register value onto the data bus
  function automatic logic [31:0] asl_widen(input logic [7:0] val);
    return {24'h00_0000, val};
  endfunction

endpackage

// ---- rtl/asl_seg_levels.sv ----
// Antenna driver segment level register bank, top level
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Source select 0 uses calibrated depth result
// - Source select 1 uses keyed segment mask
// - Calibration command updates the automatic keyed level
// - Result register shows calibrated mask, bit7 MSB
// - Failed calibration loads all ones result
// - Result register zero after reset and restore
// - Keyed mask bits disable segments when selected
// - Idle mask bits disable segments when unmodulated
// - Eight segments, bit7 2 ohm to bit0 256
// - Idle mask all ones tristates the drivers
// - Settings zero at reset and restore command
module asl_seg_levels (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        ARST_N,
  // APB register port
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  // Transmitter state
  input  wire logic        MOD_ACTIVE,
  // Depth calibration engine
  output var  logic        CAL_START,
  input  wire logic        CAL_DONE,
  input  wire logic        CAL_FAIL,
  input  wire logic [5:0]  CAL_CODE,
  input  wire logic [7:0]  CAL_MASK,
  // Antenna driver segment controls
  output var  logic [7:0]  SEG_DISABLE,
  output var  logic        DRV_TRISTATE
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  asl_bank_if bus ();

  logic                       src_sel_reg;
  logic [5:0]                 depth_code_reg;
  logic [7:0]                 keyed_mask_reg;
  logic [7:0]                 idle_mask_reg;
  logic [7:0]                 cal_result_reg;
  logic                       done_flag_reg;
  logic                       fail_flag_reg;
  asl_pkg::asl_cal_state_type cal_state_reg;
  asl_pkg::asl_cal_state_type cal_state_next;

  logic       wr_ctrl;
  logic       wr_keyed;
  logic       wr_idle;
  logic       wr_stat;
  logic       wr_cmd;
  logic       restore;
  logic       cal_req;
  logic       cal_begin;
  logic       cal_finish;
  logic       cal_busy;
  logic       wdata_src;
  logic [5:0] wdata_code;
  logic [7:0] wdata_mask;
  logic [7:0] keyed_eff;
  logic [7:0] ctrl_view;
  logic [7:0] stat_view;

  // Write strobe for one register index
  function automatic logic wr_hit(input logic       wr_en,
                                  input logic [7:0] idx,
                                  input logic [7:0] want);
    return wr_en & (idx == want);
  endfunction

  // ----------------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------------

  // APB handshake and read capture
  asl_apb_slave u_apb (
    .clk     (CLK_SYS),
    .arst_n  (ARST_N),
    .psel    (PSEL),
    .penable (PENABLE),
    .pwrite  (PWRITE),
    .paddr   (PADDR),
    .pwdata  (PWDATA),
    .prdata  (PRDATA),
    .pready  (PREADY),
    .pslverr (PSLVERR),
    .bus     (bus)
  );

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------

  // Write strobes per register
  assign wr_ctrl  = wr_hit(bus.wr, bus.idx, asl_pkg::CTRL_IDX);
  assign wr_keyed = wr_hit(bus.wr, bus.idx, asl_pkg::KEYED_IDX);
  assign wr_idle  = wr_hit(bus.wr, bus.idx, asl_pkg::IDLE_IDX);
  assign wr_stat  = wr_hit(bus.wr, bus.idx, asl_pkg::STAT_IDX);
  assign wr_cmd   = wr_hit(bus.wr, bus.idx, asl_pkg::CMD_IDX);

  // Command bits, restore takes priority over a calibration start
  assign restore  = wr_cmd & bus.wdata[asl_pkg::CMD_RESTORE];
  assign cal_req  = wr_cmd & bus.wdata[asl_pkg::CMD_CAL] & ~restore;

  // Fields of the write word
  assign wdata_src  = bus.wdata[asl_pkg::SRC_BIT];
  assign wdata_code = bus.wdata[asl_pkg::CODE_MSB:asl_pkg::CODE_LSB];
  assign wdata_mask = bus.wdata[asl_pkg::SEG_N-1:0];

  // Mapped indices; the result register accepts and ignores writes
  always_comb begin
    case (bus.idx)
      asl_pkg::CTRL_IDX,
      asl_pkg::RESULT_IDX,
      asl_pkg::KEYED_IDX,
      asl_pkg::IDLE_IDX,
      asl_pkg::STAT_IDX,
      asl_pkg::CMD_IDX: bus.hit = 1'b1;
      default:          bus.hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------

  // Control view: source select, depth code, bit 0 reads zero
  always_comb begin
    ctrl_view                                      = 8'h00;
    ctrl_view[asl_pkg::SRC_BIT]                    = src_sel_reg;
    ctrl_view[asl_pkg::CODE_MSB:asl_pkg::CODE_LSB] = depth_code_reg;
  end

  // Status view: busy, sticky done, sticky fail, the rest zero
  always_comb begin
    stat_view                     = 8'h00;
    stat_view[asl_pkg::STAT_BUSY] = cal_busy;
    stat_view[asl_pkg::STAT_DONE] = done_flag_reg;
    stat_view[asl_pkg::STAT_FAIL] = fail_flag_reg;
  end

  // Register read data, upper bits zero
  always_comb begin
    case (bus.idx)
      asl_pkg::CTRL_IDX:   bus.rdata = asl_pkg::asl_widen(ctrl_view);
      asl_pkg::RESULT_IDX: bus.rdata = asl_pkg::asl_widen(cal_result_reg);
      asl_pkg::KEYED_IDX:  bus.rdata = asl_pkg::asl_widen(keyed_mask_reg);
      asl_pkg::IDLE_IDX:   bus.rdata = asl_pkg::asl_widen(idle_mask_reg);
      asl_pkg::STAT_IDX:   bus.rdata = asl_pkg::asl_widen(stat_view);
      default:             bus.rdata = asl_pkg::DATA_ZERO;
    endcase
  end

  // ----------------------------------------------------------------------
  // Depth calibration sequencer
  // ----------------------------------------------------------------------

  // Busy while the engine runs
  assign cal_busy = (cal_state_reg == asl_pkg::CAL_RUN);

  // Start only from idle; finish on the engine's done pulse
  assign cal_begin  = cal_req & (cal_state_reg == asl_pkg::CAL_IDLE);
  assign cal_finish = CAL_DONE & cal_busy & ~restore;

  // Next state; a restore abandons a running calibration
  always_comb begin
    cal_state_next = cal_state_reg;
    case (cal_state_reg)
      asl_pkg::CAL_IDLE: begin
        if (cal_begin) begin
          cal_state_next = asl_pkg::CAL_RUN;
        end
      end
      asl_pkg::CAL_RUN: begin
        if (restore || CAL_DONE) begin
          cal_state_next = asl_pkg::CAL_IDLE;
        end
      end
      default: begin
        cal_state_next = asl_pkg::CAL_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      cal_state_reg <= asl_pkg::CAL_IDLE;
    end else begin
      cal_state_reg <= cal_state_next;
    end
  end

  // One cycle start pulse to the engine
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      CAL_START <= 1'b0;
    end else begin
      CAL_START <= cal_begin;
    end
  end

  // ----------------------------------------------------------------------
  // Control register: source select and depth code
  // ----------------------------------------------------------------------

  // Source select bit
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      src_sel_reg <= 1'b0;
    end else if (restore) begin
      src_sel_reg <= 1'b0;
    end else if (wr_ctrl) begin
      src_sel_reg <= wdata_src;
    end
  end

  // Depth code; a successful calibration wins over a software write
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      depth_code_reg <= asl_pkg::CODE_RST;
    end else if (restore) begin
      depth_code_reg <= asl_pkg::CODE_RST;
    end else if (cal_finish && !CAL_FAIL) begin
      depth_code_reg <= CAL_CODE;
    end else if (wr_ctrl) begin
      depth_code_reg <= wdata_code;
    end
  end

  // ----------------------------------------------------------------------
  // Calibration result display
  // ----------------------------------------------------------------------

  // Calibrated segment mask, all ones on failure
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      cal_result_reg <= asl_pkg::MASK_RST;
    end else if (restore) begin
      cal_result_reg <= asl_pkg::MASK_RST;
    end else if (cal_finish) begin
      if (CAL_FAIL) begin
        cal_result_reg <= asl_pkg::MASK_ALL;
      end else begin
        cal_result_reg <= CAL_MASK;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Calibration status flags
  // ----------------------------------------------------------------------

  // Sticky done flag; a new finish wins over a clear
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      done_flag_reg <= 1'b0;
    end else if (restore) begin
      done_flag_reg <= 1'b0;
    end else if (cal_finish) begin
      done_flag_reg <= 1'b1;
    end else if (wr_stat && bus.wdata[asl_pkg::STAT_DONE]) begin
      done_flag_reg <= 1'b0;
    end
  end

  // Sticky fail flag; a new failure wins over a clear
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      fail_flag_reg <= 1'b0;
    end else if (restore) begin
      fail_flag_reg <= 1'b0;
    end else if (cal_finish && CAL_FAIL) begin
      fail_flag_reg <= 1'b1;
    end else if (wr_stat && bus.wdata[asl_pkg::STAT_FAIL]) begin
      fail_flag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Segment masks
  // ----------------------------------------------------------------------

  // Keyed mask, bit 7 the 2 ohm segment down to bit 0 at 256 ohm
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      keyed_mask_reg <= asl_pkg::MASK_RST;
    end else if (restore) begin
      keyed_mask_reg <= asl_pkg::MASK_RST;
    end else if (wr_keyed) begin
      keyed_mask_reg <= wdata_mask;
    end
  end

  // Idle mask, same segment weighting
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      idle_mask_reg <= asl_pkg::MASK_RST;
    end else if (restore) begin
      idle_mask_reg <= asl_pkg::MASK_RST;
    end else if (wr_idle) begin
      idle_mask_reg <= wdata_mask;
    end
  end

  // Keyed level source: calibration result or manual mask
  always_comb begin
    if (src_sel_reg) begin
      keyed_eff = keyed_mask_reg;
    end else begin
      keyed_eff = cal_result_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Driver control
  // ----------------------------------------------------------------------

  // Registered selection between idle and keyed masks
  asl_seg_select #(
    .SEG_N (asl_pkg::SEG_N)
  ) u_sel (
    .clk         (CLK_SYS),
    .arst_n      (ARST_N),
    .mod_active  (MOD_ACTIVE),
    .idle_mask   (idle_mask_reg),
    .keyed_mask  (keyed_eff),
    .seg_disable (SEG_DISABLE),
    .tristate    (DRV_TRISTATE)
  );

endmodule
`default_nettype wire

// ---- rtl/asl_seg_select.sv ----
// Registered choice of the segment disable mask
`timescale 1ns/1ps
`default_nettype none
module asl_seg_select #(
  parameter int unsigned SEG_N = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Masks and transmitter state
  input  wire logic             mod_active,
  input  wire logic [SEG_N-1:0] idle_mask,
  input  wire logic [SEG_N-1:0] keyed_mask,
  // Driver controls
  output var  logic [SEG_N-1:0] seg_disable,
  output var  logic             tristate
);
  // One register stage: the mask swaps as a whole word, no glitches
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seg_disable <= '0;
    end else begin
      seg_disable <= mod_active ? keyed_mask : idle_mask;
    end
  end

  // All idle segments off floats the drivers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tristate <= 1'b0;
    end else begin
      tristate <= ~mod_active & (&idle_mask);
    end
  end
endmodule
`default_nettype wire

// ---- test/asl_seg_levels_bench.sv ----
// Self-checking bench for the antenna segment level bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) begin \
      fail_count++; \
      $display("wrong value at %0t: got %0h want %0h", $time, g, e); \
    end \
  end
module asl_seg_levels_bench;
  // ----------------------------------------------------------------
  // Addresses and signals
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = asl_pkg::CTRL_IDX << 2;
  localparam logic [7:0] A_RES  = asl_pkg::RESULT_IDX << 2;
  localparam logic [7:0] A_KEY  = asl_pkg::KEYED_IDX << 2;
  localparam logic [7:0] A_IDLE = asl_pkg::IDLE_IDX << 2;
  localparam logic [7:0] A_STAT = asl_pkg::STAT_IDX << 2;
  localparam logic [7:0] A_CMD  = asl_pkg::CMD_IDX << 2;
  logic        clk        = 1'b0;
  logic        arst_n     = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0000_0000;
  logic        mod_active = 1'b0;
  logic        cal_done   = 1'b0;
  logic        cal_fail   = 1'b0;
  logic [5:0]  cal_code   = 6'h00;
  logic [7:0]  cal_mask   = 8'h00;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [7:0]  seg_disable;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        cal_start;
  logic        drv_tristate;
  int          fail_count  = 0;
  int          checks_done = 0;

  // Device under test
  asl_seg_levels dut_u (
    .CLK_SYS      (clk),
    .ARST_N       (arst_n),
    .PSEL         (psel),
    .PENABLE      (penable),
    .PWRITE       (pwrite),
    .PADDR        (paddr),
    .PWDATA       (pwdata),
    .PRDATA       (prdata),
    .PREADY       (pready),
    .PSLVERR      (pslverr),
    .MOD_ACTIVE   (mod_active),
    .CAL_START    (cal_start),
    .CAL_DONE     (cal_done),
    .CAL_FAIL     (cal_fail),
    .CAL_CODE     (cal_code),
    .CAL_MASK     (cal_mask),
    .SEG_DISABLE  (seg_disable),
    .DRV_TRISTATE (drv_tristate)
  );

  // 40 MHz system clock
  always #12.5 clk = ~clk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // One APB transfer, bounded wait for ready
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    `CHK(pready, 1'b1)
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h00_0000, d});
  endtask

  // Read and compare one register
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    `CHK(rd, {24'h00_0000, e})
    `CHK(err, 1'b0)
  endtask

  // Read that must be refused
  task automatic rderr(input logic [7:0] a);
    xfer(1'b0, a, 32'h0000_0000);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0000_0000)
  endtask

  task automatic regs(input logic [7:0] c, input logic [7:0] r,
                      input logic [7:0] k, input logic [7:0] i);
    rdc(A_CTRL, c);
    rdc(A_RES, r);
    rdc(A_KEY, k);
    rdc(A_IDLE, i);
  endtask

  // Driver outputs once the registered path has settled
  task automatic seg(input logic [7:0] e, input logic t);
    repeat (3) @(posedge clk);
    `CHK(seg_disable, e)
    `CHK(drv_tristate, t)
  endtask

  // Start calibration and answer as the engine
  task automatic cal(input logic f, input logic [5:0] c,
                     input logic [7:0] m);
    int n;
    wr(A_CMD, 8'h02);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cal_start !== 1'b1 && n < 10);
    `CHK(cal_start, 1'b1)
    cal_done <= 1'b1;
    cal_fail <= f;
    cal_code <= c;
    cal_mask <= m;
    @(posedge clk);
    cal_done <= 1'b0;
  endtask

  task automatic done_test(input string s);
    $display("test %s finished", s);
  endtask

  // Counts, verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    regs(8'h00, 8'h00, 8'h00, 8'h00);
    seg(8'h00, 1'b0);
    done_test("reset");
    // Refused and read-only places
    rderr(8'h00);
    rderr(A_IDLE + 8'h01);
    wr(A_RES, 8'haa);
    `CHK(err, 1'b0)
    rdc(A_RES, 8'h00);
    done_test("access");
    // Normal level, tristate, and swap to keyed level
    wr(A_IDLE, 8'hc0);
    seg(8'hc0, 1'b0);
    wr(A_IDLE, 8'hff);
    seg(8'hff, 1'b1);
    mod_active <= 1'b1;
    seg(8'h00, 1'b0);
    mod_active <= 1'b0;
    wr(A_IDLE, 8'h0f);
    done_test("idle");
    // Manual keyed mask
    wr(A_CTRL, 8'h87);
    wr(A_KEY, 8'h5a);
    regs(8'h86, 8'h00, 8'h5a, 8'h0f);
    seg(8'h0f, 1'b0);
    mod_active <= 1'b1;
    seg(8'h5a, 1'b0);
    done_test("manual");
    // Automatic level from calibration, then a failed run
    wr(A_CTRL, 8'h00);
    seg(8'h00, 1'b0);
    cal(1'b0, 6'h15, 8'h3c);
    regs(8'h2a, 8'h3c, 8'h5a, 8'h0f);
    rdc(A_STAT, 8'h02);
    seg(8'h3c, 1'b0);
    cal(1'b1, 6'h07, 8'h11);
    regs(8'h2a, 8'hff, 8'h5a, 8'h0f);
    rdc(A_STAT, 8'h06);
    wr(A_STAT, 8'h06);
    rdc(A_STAT, 8'h00);
    seg(8'hff, 1'b0);
    done_test("calibration");
    // Restore defaults, also abandoning a running calibration
    wr(A_CMD, 8'h02);
    rdc(A_STAT, 8'h01);
    wr(A_CMD, 8'h01);
    regs(8'h00, 8'h00, 8'h00, 8'h00);
    rdc(A_STAT, 8'h00);
    seg(8'h00, 1'b0);
    done_test("restore");
    results();
  end

  // Watchdog: the tests need a few hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    results();
  end
endmodule
`default_nettype wire

// ---- test/asl_seg_levels_props.sv ----
// Port checker for the antenna segment level bank
`timescale 1ns/1ps
`default_nettype none
module asl_seg_levels_props (
  // Clock and reset
  input wire logic        CLK_SYS,
  input wire logic        ARST_N,
  // APB port
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Transmitter and driver side
  input wire logic        MOD_ACTIVE,
  input wire logic        CAL_START,
  input wire logic [7:0]  SEG_DISABLE,
  input wire logic        DRV_TRISTATE
);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  // Bus answers after exactly one wait state
  a_wait_state: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
    else $error("ready not on second access cycle");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error flag without ready");
  a_unaligned_err: assert property (PREADY && PADDR[1:0] != 2'b00 |-> PSLVERR)
    else $error("unaligned access not refused");
  a_err_read_zero: assert property (PREADY && PSLVERR && !PWRITE
    |-> PRDATA == 32'h0000_0000)
    else $error("refused read returned data");
  a_upper_zero: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h0)
    else $error("upper read bits not zero");
  // Calibration start follows a command write
  a_start_cause: assert property (CAL_START |-> $past(PSEL && PENABLE
    && PREADY && PWRITE && PADDR == 8'hfc && PWDATA[1:0] == 2'b10))
    else $error("calibration start without command");
  a_start_pulse: assert property (CAL_START |=> !CAL_START)
    else $error("calibration start longer than one cycle");
  // Tristate only in the unmodulated state with all segments off
  a_tristate_cause: assert property (DRV_TRISTATE
    |-> !$past(MOD_ACTIVE) && SEG_DISABLE == 8'hff)
    else $error("tristate without idle all ones");
  a_keyed_no_tri: assert property ($past(MOD_ACTIVE) |-> !DRV_TRISTATE)
    else $error("tristate during modulated state");

  // Main scenarios
  c_refused: cover property (PREADY && PSLVERR);
  c_cal_start: cover property (CAL_START);
  c_tristate: cover property (DRV_TRISTATE);
  c_keyed: cover property (MOD_ACTIVE && SEG_DISABLE != 8'h00);
endmodule

bind asl_seg_levels asl_seg_levels_props props_u (
  .CLK_SYS      (CLK_SYS),
  .ARST_N       (ARST_N),
  .PSEL         (PSEL),
  .PENABLE      (PENABLE),
  .PWRITE       (PWRITE),
  .PADDR        (PADDR),
  .PWDATA       (PWDATA),
  .PRDATA       (PRDATA),
  .PREADY       (PREADY),
  .PSLVERR      (PSLVERR),
  .MOD_ACTIVE   (MOD_ACTIVE),
  .CAL_START    (CAL_START),
  .SEG_DISABLE  (SEG_DISABLE),
  .DRV_TRISTATE (DRV_TRISTATE)
);
`default_nettype wire
